/* File: ccp_pkg.sv */
// constants, mode codes and carrier types of the capture/compare unit
// assumes a 16-bit timer and an a/d converter outside, on the same sys_clk
`default_nettype none
package ccp_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [3:0] CCP_OFS_CONTROL = 4'h0;
    localparam logic [3:0] CCP_OFS_LOW = 4'h4;
    localparam logic [3:0] CCP_OFS_HIGH = 4'h8;
    localparam logic [3:0] CCP_OFS_FLAG = 4'hC;
    // unit_control fields
    localparam int CCP_MODE_LSB = 0;
    localparam int CCP_DUTY_LSB = 4;
    localparam logic [5:0] CCP_CONTROL_MASK = 6'h3F;
    // reset values and axi response codes
    localparam logic [7:0] CCP_CONTROL_RST = 8'h00;
    localparam logic [15:0] CCP_PAIR_RST = 16'h0000;
    localparam logic [3:0] CCP_PSCNT_RST = 4'h0;
    localparam logic [1:0] CCP_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCP_RESP_SLVERR = 2'h2;
    // prescaler terminal counts
    localparam logic [3:0] CCP_PS4_LAST = 4'h3;
    localparam logic [3:0] CCP_PS16_LAST = 4'hF;

    typedef enum logic [3:0] {
        CCP_MODE_OFF = 4'h0,
        CCP_MODE_RSV1 = 4'h1,
        CCP_MODE_TOGGLE = 4'h2,
        CCP_MODE_RSV3 = 4'h3,
        CCP_MODE_CAP_FALL = 4'h4,
        CCP_MODE_CAP_RISE = 4'h5,
        CCP_MODE_CAP_RISE4 = 4'h6,
        CCP_MODE_CAP_RISE16 = 4'h7,
        CCP_MODE_CMP_SET = 4'h8,
        CCP_MODE_CMP_CLR = 4'h9,
        CCP_MODE_CMP_SOFT = 4'hA,
        CCP_MODE_CMP_SPECIAL = 4'hB
    } ccp_mode_t;

    typedef struct packed {
        logic awvalid;
        logic [3:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [3:0] araddr;
        logic rready;
    } ccp_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccp_axi_rsp_t;
endpackage : ccp_pkg
`default_nettype wire

/* File: ccp_capture_compare_unit.sv */
// capture/compare unit with its axi4-lite register slave
// assumes timer_count and timer_tick come from a timer on sys_clk; the pin is asynchronous
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`default_nettype none

// Behaviour
// - capture copies full 16-bit timer count
// - capture on fall, rise, 4th or 16th rise
// - capture sets flag; only software clears it
// - new capture overwrites unread value
// - edges seen on pin level, any direction
// - prescaler cleared when off, non-capture, reset
// - prescaler kept across direct prescaler changes
// - capture keeps working while asleep
// - compare match acts and sets flag together
// - zero control forces compare latch low
// - mode 1010 only sets flag
// - mode 1011 resets timer, starts conversion
// - trigger immediate, timer cleared next tick
// - trigger reset never sets overflow flag
// - match removed before tick cancels reset
// - compare not acted on during sleep
// - capture mode codes 0100 to 0111
// - mode 0010 toggles output on match
// - modes 1000/1001 init low/high, set/clear
// - mode 0000 off, internal state reset
module ccp_capture_compare_unit
    import ccp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register bus
    input wire ccp_axi_req_t axi_req,
    output ccp_axi_rsp_t axi_rsp,
    // unit pin
    input wire logic event_unit_pin,
    output logic pin_out,
    output logic pin_drive,
    // timer, converter and sleep
    input wire logic [15:0] timer_count,
    input wire logic timer_tick,
    input wire logic adc_enabled,
    input wire logic sleep,
    output logic special_event_trigger,
    output logic timer_reset_req,
    output logic adc_start,
    // status
    output logic unit_event_flag
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [5:0] control;
        logic [15:0] pair;
        logic flag;
        logic [1:0] pin_sync;
        logic pin_prev;
        logic [3:0] pscnt;
        logic cmp_latch;
        logic match_q;
        logic rst_pend;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccp_state_t;

    ccp_state_t st;
    ccp_state_t next_st;

    ccp_mode_t mode;
    logic is_capture;
    logic is_compare;
    logic rise;
    logic fall;
    logic capture_evt;
    logic match;
    logic match_evt;
    logic do_write;
    logic [3:0] ps_last;
    logic [7:0] wbyte;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        mode = ccp_mode_t'(st.control[CCP_MODE_LSB +: 4]);
        is_capture = (mode == CCP_MODE_CAP_FALL) || (mode == CCP_MODE_CAP_RISE)
            || (mode == CCP_MODE_CAP_RISE4) || (mode == CCP_MODE_CAP_RISE16);
        // reserved codes fall in neither group, so they stay idle
        is_compare = (mode == CCP_MODE_TOGGLE) || (mode == CCP_MODE_CMP_SET)
            || (mode == CCP_MODE_CMP_CLR) || (mode == CCP_MODE_CMP_SOFT)
            || (mode == CCP_MODE_CMP_SPECIAL);
        // edges come from the synchronised pad level, whoever drives it
        rise = st.pin_sync[1] && !st.pin_prev;
        fall = !st.pin_sync[1] && st.pin_prev;
        ps_last = (mode == CCP_MODE_CAP_RISE4) ? CCP_PS4_LAST : CCP_PS16_LAST;
        case (mode)
            CCP_MODE_CAP_FALL: capture_evt = fall;
            CCP_MODE_CAP_RISE: capture_evt = rise;
            CCP_MODE_CAP_RISE4,
            CCP_MODE_CAP_RISE16: capture_evt = rise && ((st.pscnt & ps_last) == ps_last);
            default: capture_evt = 1'b0;
        endcase
        // compare match is masked by the sleep input; sys_clk keeps running, so capture goes on
        match = is_compare && !sleep && (st.pair == timer_count);
        match_evt = match && !st.match_q;
        do_write = st.aw_held && st.w_held && !st.bvalid;
        wbyte = st.w_data[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        // two-stage synchroniser; only the second stage feeds logic
        next_st.pin_sync = {st.pin_sync[0], event_unit_pin};
        next_st.pin_prev = st.pin_sync[1];

        // capture prescaler
        if (!is_capture)
        begin
            next_st.pscnt = CCP_PSCNT_RST;
        end
        else if (rise && ((mode == CCP_MODE_CAP_RISE4) || (mode == CCP_MODE_CAP_RISE16)))
        begin
            // a direct switch between prescalers keeps the count, so a stray
            // capture may follow; software clears control first to avoid it
            next_st.pscnt = st.pscnt + 4'h1;
        end

        // capture: later captures overwrite unread data, never stalled
        if (capture_evt)
        begin
            next_st.pair = timer_count;
        end

        // compare output latch
        next_st.match_q = match;
        if (match_evt)
        begin
            case (mode)
                CCP_MODE_TOGGLE: next_st.cmp_latch = !st.cmp_latch;
                CCP_MODE_CMP_SET: next_st.cmp_latch = 1'b1;
                CCP_MODE_CMP_CLR: next_st.cmp_latch = 1'b0;
                default: next_st.cmp_latch = st.cmp_latch;
            endcase
        end

        // timer reset waits for the next tick and is dropped if the match goes away
        if (mode != CCP_MODE_CMP_SPECIAL || !match || timer_tick)
        begin
            next_st.rst_pend = 1'b0;
        end
        else if (match)
        begin
            next_st.rst_pend = 1'b1;
        end

        // axi write channels are taken independently, then acted on together
        if (axi_req.awvalid && !st.aw_held)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !st.w_held)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = axi_req.wdata;
            next_st.w_lane0 = axi_req.wstrb[0];
        end
        if (do_write)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = CCP_RESP_OKAY;
            if (st.aw_addr == CCP_OFS_CONTROL)
            begin
                if (st.w_lane0)
                begin
                    next_st.control = wbyte[5:0] & CCP_CONTROL_MASK;
                    // a mode write presets the output latch; zero forces it low
                    if (wbyte[3:0] == CCP_MODE_CMP_CLR)
                    begin
                        next_st.cmp_latch = 1'b1;
                    end
                    else
                    begin
                        next_st.cmp_latch = 1'b0;
                    end
                end
            end
            else if (st.aw_addr == CCP_OFS_LOW)
            begin
                if (st.w_lane0 && !capture_evt)
                begin
                    next_st.pair[7:0] = wbyte;
                end
            end
            else if (st.aw_addr == CCP_OFS_HIGH)
            begin
                if (st.w_lane0 && !capture_evt)
                begin
                    next_st.pair[15:8] = wbyte;
                end
            end
            else if (st.aw_addr == CCP_OFS_FLAG)
            begin
                // writing zero clears the flag; writing one also sets it
                if (st.w_lane0)
                begin
                    next_st.flag = wbyte[0];
                end
            end
            else
            begin
                next_st.bresp = CCP_RESP_SLVERR;
            end
        end
        else if (st.bvalid && axi_req.bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // hardware set wins over a software clear in the same cycle
        if (capture_evt || match_evt)
        begin
            next_st.flag = 1'b1;
        end

        // read channel: one read at a time, data from flip-flops
        if (axi_req.arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = CCP_RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            if (axi_req.araddr == CCP_OFS_CONTROL)
            begin
                next_st.rdata[5:0] = st.control;
            end
            else if (axi_req.araddr == CCP_OFS_LOW)
            begin
                next_st.rdata[7:0] = st.pair[7:0];
            end
            else if (axi_req.araddr == CCP_OFS_HIGH)
            begin
                next_st.rdata[7:0] = st.pair[15:8];
            end
            else if (axi_req.araddr == CCP_OFS_FLAG)
            begin
                next_st.rdata[0] = st.flag;
            end
            else
            begin
                next_st.rresp = CCP_RESP_SLVERR;
            end
        end
        else if (st.rvalid && axi_req.rready)
        begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        axi_rsp.awready = !st.aw_held;
        axi_rsp.wready = !st.w_held;
        axi_rsp.bvalid = st.bvalid;
        axi_rsp.bresp = st.bresp;
        axi_rsp.arready = !st.rvalid;
        axi_rsp.rvalid = st.rvalid;
        axi_rsp.rdata = st.rdata;
        axi_rsp.rresp = st.rresp;
        // soft-interrupt and special modes leave the pin to the port logic
        pin_drive = (mode == CCP_MODE_TOGGLE) || (mode == CCP_MODE_CMP_SET)
            || (mode == CCP_MODE_CMP_CLR);
        pin_out = st.cmp_latch;
        special_event_trigger = match && (mode == CCP_MODE_CMP_SPECIAL);
        // this request is distinct from overflow, so the timer leaves its flag alone
        timer_reset_req = st.rst_pend && timer_tick && match;
        adc_start = special_event_trigger && !st.match_q && adc_enabled;
        unit_event_flag = st.flag;
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_rise_seen;
        !st.pin_prev && st.pin_sync[1];
    endsequence

    sequence s_capture_taken;
        ##1 (st.pair == $past(timer_count)) && st.flag;
    endsequence

    a_capture_latches_count: assert property (@(posedge sys_clk) disable iff (rst)
        capture_evt |-> s_capture_taken)
        else $error("capture did not store timer count");

    a_capture_rise_edge: assert property (@(posedge sys_clk) disable iff (rst)
        ((mode == CCP_MODE_CAP_RISE) and s_rise_seen) |-> capture_evt)
        else $error("rising edge missed in rise mode");

    a_flag_stays_set: assert property (@(posedge sys_clk) disable iff (rst)
        st.flag && !(do_write && st.aw_addr == CCP_OFS_FLAG) |=> st.flag)
        else $error("flag dropped without software");

    a_prescale_cleared: assert property (@(posedge sys_clk) disable iff (rst)
        !is_capture |=> st.pscnt == CCP_PSCNT_RST)
        else $error("prescaler not cleared outside capture");

    a_prescale_fourth: assert property (@(posedge sys_clk) disable iff (rst)
        capture_evt && (mode == CCP_MODE_CAP_RISE4) |-> st.pscnt[1:0] == 2'h3)
        else $error("fourth-edge capture out of step");

    a_match_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        match_evt |=> st.flag)
        else $error("compare match did not set flag");

    a_toggle_on_match: assert property (@(posedge sys_clk) disable iff (rst)
        match_evt && (mode == CCP_MODE_TOGGLE) |=> pin_out != $past(pin_out))
        else $error("toggle mode did not toggle");

    a_zero_control_low: assert property (@(posedge sys_clk) disable iff (rst)
        do_write && st.aw_addr == CCP_OFS_CONTROL && st.w_lane0 && wbyte[3:0] == 4'h0
        |=> !pin_out && !pin_drive)
        else $error("control zero left latch high");

    a_special_no_pin: assert property (@(posedge sys_clk) disable iff (rst)
        mode inside {CCP_MODE_CMP_SPECIAL, CCP_MODE_CMP_SOFT} |-> !pin_drive)
        else $error("pin driven in soft or special mode");

    a_reset_after_trigger: assert property (@(posedge sys_clk) disable iff (rst)
        timer_reset_req |-> $past(special_event_trigger) && special_event_trigger)
        else $error("timer reset without held match");

    a_reserved_idle: assert property (@(posedge sys_clk) disable iff (rst)
        mode inside {CCP_MODE_RSV1, CCP_MODE_RSV3} |-> !capture_evt && !match)
        else $error("reserved mode acted");

endmodule : ccp_capture_compare_unit
`default_nettype wire

/* File: ccp_timer_model.sv */
// timer standing beside the capture/compare unit
// assumes the bench steers run and load on sys_clk rising edges
`default_nettype none
module ccp_timer_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench control
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_val,
    // unit side
    input wire logic timer_reset_req,
    output logic [15:0] timer_count,
    output logic timer_tick
);
    logic [1:0] div;

    // counts at a quarter of sys_clk, never from the undivided clock
    assign timer_tick = run && (div == 2'h3);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            div <= 2'h0;
            timer_count <= 16'h0000;
        end
        else if (load)
        begin
            div <= 2'h0;
            timer_count <= load_val;
        end
        else if (run)
        begin
            div <= div + 2'h1;
            // a pending trigger reset lands on the tick instead of the increment
            if (timer_tick)
                timer_count <= timer_reset_req ? 16'h0000 : timer_count + 16'h0001;
        end
    end
endmodule : ccp_timer_model
`default_nettype wire

/* File: test_ccp_capture_compare_unit.sv */
// self-checking bench: axi4-lite register tasks, pin stimulus, timer model
// assumes the unit answers within the cycle ceiling of the watchdog
`default_nettype none
module test_ccp_capture_compare_unit
    import ccp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ccp_axi_req_t req;
    ccp_axi_rsp_t rsp;
    logic pin, pin_out, pin_drive, run, load, adc_en, sleep;
    logic trig, tim_rst, adc_start, flag, tick;
    logic [15:0] load_val, tcount;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [3:0] cm [4] = '{4'h2, 4'h8, 4'h9, 4'hA};
    logic [3:0] rm [3] = '{4'h1, 4'h3, 4'hA};
    logic [3:0] ci = 4'h4;
    logic [3:0] co = 4'h3;
    logic [3:0] cd = 4'h7;

    ccp_capture_compare_unit u_ccp_capture_compare_unit (
        .sys_clk(sys_clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .event_unit_pin(pin), .pin_out(pin_out), .pin_drive(pin_drive),
        .timer_count(tcount), .timer_tick(tick), .adc_enabled(adc_en), .sleep(sleep),
        .special_event_trigger(trig), .timer_reset_req(tim_rst), .adc_start(adc_start),
        .unit_event_flag(flag));
    ccp_timer_model u_ccp_timer_model (
        .sys_clk(sys_clk), .rst(rst), .run(run), .load(load), .load_val(load_val),
        .timer_reset_req(tim_rst), .timer_count(tcount), .timer_tick(tick));

    always #2.5 sys_clk = ~sys_clk;

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        // hang guard, well above the full sequence length
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // entered and left just after a rising edge; bready stays high throughout
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        while (!(aw && w))
        begin
            @(negedge sys_clk);
            aw = aw || (rsp.awready === 1'b1);
            w = w || (rsp.wready === 1'b1);
            @(posedge sys_clk);
            if (aw)
                req.awvalid <= 1'b0;
            if (w)
                req.wvalid <= 1'b0;
        end
        do @(negedge sys_clk); while (rsp.bvalid !== 1'b1);
        chk(rsp.bresp, er, "bresp");
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do @(negedge sys_clk); while (rsp.arready !== 1'b1);
        @(posedge sys_clk);
        req.arvalid <= 1'b0;
        do @(negedge sys_clk); while (rsp.rvalid !== 1'b1);
        chk(rsp.rdata, {24'h000000, e}, "rdata");
        chk(rsp.rresp, er, "rresp");
        @(posedge sys_clk);
    endtask : rd

    // off first, then the new mode, then drop any spurious flag
    task automatic mode(input logic [3:0] m);
        wr(CCP_OFS_CONTROL, 8'h00, CCP_RESP_OKAY);
        wr(CCP_OFS_CONTROL, {4'h0, m}, CCP_RESP_OKAY);
        wr(CCP_OFS_FLAG, 8'h00, CCP_RESP_OKAY);
    endtask : mode

    task automatic tset(input logic [15:0] v);
        load <= 1'b1;
        load_val <= v;
        @(posedge sys_clk);
        load <= 1'b0;
    endtask : tset

    task automatic rises(input int n);
        repeat (n)
        begin
            pin <= 1'b1;
            repeat (6) @(posedge sys_clk);
            pin <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
    endtask : rises

    initial
    begin
        req = '{bready: 1'b1, rready: 1'b1, default: '0};
        {pin, run, load, adc_en, sleep} = 5'h00;
        load_val = 16'h0000;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(CCP_OFS_CONTROL, 8'h00, CCP_RESP_OKAY);
        rd(CCP_OFS_HIGH, 8'h00, CCP_RESP_OKAY);
        rd(CCP_OFS_FLAG, 8'h00, CCP_RESP_OKAY);
        rd(4'h2, 8'h00, CCP_RESP_SLVERR);
        wr(4'h2, 8'hFF, CCP_RESP_SLVERR);
        // falling-edge capture of a frozen count
        pin <= 1'b1; // pin kept as input, the pad is driven from outside
        tset(16'hA5C3);
        mode(4'h4);
        pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(CCP_OFS_LOW, 8'hC3, CCP_RESP_OKAY);
        rd(CCP_OFS_HIGH, 8'hA5, CCP_RESP_OKAY);
        repeat (20) @(posedge sys_clk);
        rd(CCP_OFS_FLAG, 8'h01, CCP_RESP_OKAY);
        // unread value overwritten by the next rise
        mode(4'h5);
        tset(16'h1234);
        rises(1);
        tset(16'h5678);
        rises(1);
        rd(CCP_OFS_LOW, 8'h78, CCP_RESP_OKAY);
        rd(CCP_OFS_HIGH, 8'h56, CCP_RESP_OKAY);
        // prescalers: nothing before the nth rise, a capture on it
        for (int i = 0; i < 2; i++)
        begin
            mode(4'h6 + 4'(i));
            rises(i == 0 ? 3 : 15);
            rd(CCP_OFS_FLAG, 8'h00, CCP_RESP_OKAY);
            rises(1);
            rd(CCP_OFS_FLAG, 8'h01, CCP_RESP_OKAY);
        end
        // direct prescaler switch keeps the count of rises
        mode(4'h6);
        rises(2);
        wr(CCP_OFS_CONTROL, 8'h07, CCP_RESP_OKAY);
        wr(CCP_OFS_FLAG, 8'h00, CCP_RESP_OKAY);
        rises(13);
        rd(CCP_OFS_FLAG, 8'h00, CCP_RESP_OKAY);
        rises(1);
        rd(CCP_OFS_FLAG, 8'h01, CCP_RESP_OKAY);
        // compare modes against a pair of 0x0010
        wr(CCP_OFS_LOW, 8'h10, CCP_RESP_OKAY);
        wr(CCP_OFS_HIGH, 8'h00, CCP_RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            // clear the count first: a leftover count equal to the pair would
            // match as soon as the mode lands and spoil the initial level
            tset(16'h0000);
            mode(cm[i]);
            chk(pin_drive, cd[i], "drive");
            chk(pin_out, ci[i], "init");
            run <= 1'b1;
            for (int n = 0; n < 200 && flag !== 1'b1; n++) @(negedge sys_clk);
            chk(pin_out, co[i], "pin");
            chk(flag, 1'b1, "flag");
            @(posedge sys_clk);
            run <= 1'b0;
            wr(CCP_OFS_CONTROL, 8'h00, CCP_RESP_OKAY);
            chk(pin_out, 1'b0, "off");
        end
        // special event trigger: immediate, timer cleared on the next tick
        tset(16'h0000);
        mode(4'hB);
        adc_en <= 1'b1;
        run <= 1'b1;
        for (int n = 0; n < 200 && trig !== 1'b1; n++) @(negedge sys_clk);
        chk(adc_start, 1'b1, "adc");
        chk(pin_drive, 1'b0, "drive");
        chk(tcount, 16'h0010, "count");
        for (int n = 0; n < 8 && tim_rst !== 1'b1; n++) @(negedge sys_clk);
        chk(tick, 1'b1, "tick");
        @(negedge sys_clk);
        chk(tcount, 16'h0000, "cleared");
        chk(flag, 1'b1, "flag");
        @(posedge sys_clk);
        run <= 1'b0;
        adc_en <= 1'b0;
        // reserved codes and compare in sleep stay silent
        for (int i = 0; i < 3; i++)
        begin
            mode(rm[i]);
            sleep <= (i == 2);
            tset(16'h0000);
            run <= 1'b1;
            pin <= 1'b1;
            repeat (100) @(posedge sys_clk);
            {run, pin, sleep} <= 3'h0;
            repeat (6) @(posedge sys_clk);
            rd(CCP_OFS_FLAG, 8'h00, CCP_RESP_OKAY);
        end
        // capture goes on while asleep
        mode(4'h5);
        sleep <= 1'b1;
        rises(1);
        rd(CCP_OFS_FLAG, 8'h01, CCP_RESP_OKAY);
        sleep <= 1'b0;
        report_and_stop();
    end
endmodule : test_ccp_capture_compare_unit
`default_nettype wire
